// ===== src/tsv_pkg.sv
// package of constants and types for the trap status and vector report block
package tsv_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [3:0] TSV_SOFT_TRAP_OFS = 4'h0;
   localparam logic [3:0] TSV_HARD_TRAP_OFS = 4'h4;
   localparam logic [3:0] TSV_VECTOR_OFS = 4'h8;
   localparam logic [3:0] TSV_IRQ_MASK_OFS = 4'hc;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int TSV_DMA_ERR_BIT = 5;
   localparam int TSV_LOOP_OVF_BIT = 4;
   localparam int TSV_SW_HARD_BIT = 0;
   localparam int TSV_LEVEL_LSB = 8;
   localparam int TSV_VECTOR_LSB = 0;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] TSV_STATUS_RST = 16'h0000;
   localparam logic [2:0] TSV_MASK_RST = 3'h0;
   localparam logic [3:0] TSV_LEVEL_RST = 4'h0;
   localparam logic [7:0] TSV_VECTOR_RST = 8'h00;
   // ------------------------------------------------------------
   // vector codes
   // ------------------------------------------------------------
   localparam logic [7:0] TSV_VEC_ADDR_ERR = 8'h01;
   localparam logic [7:0] TSV_VEC_HARD_TRAP = 8'h02;
   localparam logic [7:0] TSV_VEC_STACK_ERR = 8'h03;
   localparam logic [7:0] TSV_VEC_MATH_ERR = 8'h04;
   localparam logic [7:0] TSV_VEC_DMA_ERR = 8'h05;
   localparam logic [7:0] TSV_VEC_SOFT_ERR = 8'h06;
   localparam logic [7:0] TSV_VEC_RSVD_LO = 8'h07;
   localparam logic [7:0] TSV_VEC_EXT_IRQ0 = 8'h08;
   localparam logic [7:0] TSV_VEC_IN_CAP1 = 8'h09;
   localparam logic [7:0] TSV_VEC_RSVD_HI = 8'hff;

   // pending interrupt report from the dispatcher
   typedef struct packed {
      logic valid;
      logic [3:0] level;
      logic [7:0] vector;
   } tsv_pending_type;

   // trap events, one cycle pulses
   typedef struct packed {
      logic dma_addr_err;
      logic loop_stack_ovf;
      logic sw_hard_trap;
   } tsv_event_type;
endpackage

// ===== src/tsv_trap_status.sv
// trap status flags, vector report and wishbone slave
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// [RL1] dma address error sets soft bit 5
// [RL2] loop stack overflow sets soft bit 4
// [RL3] software hard trap sets hard bit 0
// [RL4] unimplemented bits read as zero
// [RL5] priority level in report bits 11:8
// [RL6] pending vector number in bits 7:0
// [RL7] trap vectors one through six
// [RL8] external line 8, capture channel 9
// [RL9] vectors 7 and 255 never reported
// [RL10] flags writable, all clear at reset
module tsv_trap_status
   import tsv_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire tsv_event_type event_i,
   input wire tsv_pending_type pend_i,
   output logic irq_o
);
   logic dma_flag_q;
   logic loop_flag_q;
   logic hard_flag_q;
   logic [2:0] mask_q;
   logic ack_q;
   logic err_q;
   logic [31:0] dat_q;
   logic irq_q;
   logic [3:0] level;
   logic [7:0] vector;
   logic req;
   logic wr_lo;
   logic hit;
   logic [15:0] soft_rd;
   logic [15:0] hard_rd;
   logic [15:0] vec_rd;
   logic [31:0] rd_d;
   logic sel_soft;
   logic sel_hard;
   logic sel_vec;
   logic sel_mask;
   logic rd_req;
   logic clr_dma;
   logic clr_loop;
   logic clr_hard;
   logic dma_flag_d;
   logic loop_flag_d;
   logic hard_flag_d;
   logic [2:0] flags;
   logic [2:0] armed;
   logic irq_d;
   logic ack_d;
   logic err_d;
   logic [31:0] dat_d;
   logic [15:0] mask_rd;

   // ------------------------------------------------------------
   // local sizes
   // ------------------------------------------------------------
   localparam int REG_W = 16;
   localparam int LEVEL_W = 4;
   localparam int VECTOR_W = 8;
   localparam int MASK_W = 3;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (TSV_DMA_ERR_BIT >= REG_W) begin : g_bad_dma
      $error("dma flag position outside register");
   end
   if (TSV_LOOP_OVF_BIT >= REG_W) begin : g_bad_loop
      $error("loop flag position outside register");
   end
   if (TSV_SW_HARD_BIT >= REG_W) begin : g_bad_hard
      $error("hard flag position outside register");
   end
   if (TSV_DMA_ERR_BIT == TSV_LOOP_OVF_BIT) begin : g_bad_soft
      $error("soft flags share one position");
   end
   if (TSV_LEVEL_LSB + LEVEL_W > REG_W) begin : g_bad_level
      $error("level field outside register");
   end
   if (TSV_VECTOR_LSB + VECTOR_W > TSV_LEVEL_LSB) begin : g_bad_vector
      $error("vector field overlaps level field");
   end
   if ($bits(TSV_MASK_RST) != MASK_W) begin : g_bad_mask
      $error("mask reset value of wrong width");
   end
   if ($bits(tsv_event_type) != MASK_W) begin : g_bad_event
      $error("one mask bit per event needed");
   end
   if (TSV_SOFT_TRAP_OFS == TSV_HARD_TRAP_OFS || TSV_VECTOR_OFS == TSV_IRQ_MASK_OFS) begin : g_bad_ofs
      $error("register offsets collide");
   end

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
   assign wr_lo = req && wb_we_i && wb_sel_i[0];
   assign rd_req = req && !wb_we_i;
   assign sel_soft = (wb_adr_i == TSV_SOFT_TRAP_OFS);
   assign sel_hard = (wb_adr_i == TSV_HARD_TRAP_OFS);
   assign sel_vec = (wb_adr_i == TSV_VECTOR_OFS);
   assign sel_mask = (wb_adr_i == TSV_IRQ_MASK_OFS);
   assign hit = sel_soft || sel_hard || sel_vec || sel_mask;

   // ------------------------------------------------------------
   // write-one-clear strobes, low byte lane only
   // ------------------------------------------------------------
   assign clr_dma = wr_lo && sel_soft && wb_dat_i[TSV_DMA_ERR_BIT]; // [RL10]
   assign clr_loop = wr_lo && sel_soft && wb_dat_i[TSV_LOOP_OVF_BIT]; // [RL10]
   assign clr_hard = wr_lo && sel_hard && wb_dat_i[TSV_SW_HARD_BIT]; // [RL10]

   // ------------------------------------------------------------
   // trap flag next values, set wins over write-one-clear
   // ------------------------------------------------------------
   always_comb begin
      dma_flag_d = dma_flag_q;
      if (event_i.dma_addr_err) begin
         dma_flag_d = 1'b1; // [RL1]
      end else if (clr_dma) begin
         dma_flag_d = 1'b0; // [RL10]
      end
   end

   always_comb begin
      loop_flag_d = loop_flag_q;
      if (event_i.loop_stack_ovf) begin
         loop_flag_d = 1'b1; // [RL2]
      end else if (clr_loop) begin
         loop_flag_d = 1'b0; // [RL10]
      end
   end

   always_comb begin
      hard_flag_d = hard_flag_q;
      if (event_i.sw_hard_trap) begin
         hard_flag_d = 1'b1; // [RL3]
      end else if (clr_hard) begin
         hard_flag_d = 1'b0; // [RL10]
      end
   end

   // ------------------------------------------------------------
   // trap flag registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dma_flag_q <= TSV_STATUS_RST[TSV_DMA_ERR_BIT]; // [RL10]
      end else begin
         dma_flag_q <= dma_flag_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_flag_q <= TSV_STATUS_RST[TSV_LOOP_OVF_BIT]; // [RL10]
      end else begin
         loop_flag_q <= loop_flag_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hard_flag_q <= TSV_STATUS_RST[TSV_SW_HARD_BIT]; // [RL10]
      end else begin
         hard_flag_q <= hard_flag_d;
      end
   end

   // ------------------------------------------------------------
   // interrupt mask: bit2 dma, bit1 loop, bit0 hard
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= TSV_MASK_RST;
      end else if (wr_lo && sel_mask) begin
         mask_q <= wb_dat_i[2:0];
      end
   end

   // ------------------------------------------------------------
   // interrupt request, level while unmasked flag set
   // ------------------------------------------------------------
   assign flags = {dma_flag_q, loop_flag_q, hard_flag_q};
   assign armed = flags & mask_q;
   assign irq_d = |armed;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // ------------------------------------------------------------
   // vector report
   // ------------------------------------------------------------
   tsv_vector_filter u_filter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pend_i(pend_i),
      .level_o(level),
      .vector_o(vector)
   );

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb begin
      soft_rd = 16'h0000; // [RL4]
      soft_rd[TSV_DMA_ERR_BIT] = dma_flag_q;
      soft_rd[TSV_LOOP_OVF_BIT] = loop_flag_q;
      hard_rd = 16'h0000; // [RL4]
      hard_rd[TSV_SW_HARD_BIT] = hard_flag_q;
      vec_rd = 16'h0000; // [RL4]
      vec_rd[TSV_LEVEL_LSB +: 4] = level; // [RL5]
      vec_rd[TSV_VECTOR_LSB +: 8] = vector; // [RL6]
      mask_rd = 16'h0000;
      mask_rd[MASK_W-1:0] = mask_q;
   end

   // ------------------------------------------------------------
   // register select
   // ------------------------------------------------------------
   always_comb begin
      case (wb_adr_i)
         TSV_SOFT_TRAP_OFS: begin
            rd_d = {16'h0000, soft_rd};
         end
         TSV_HARD_TRAP_OFS: begin
            rd_d = {16'h0000, hard_rd};
         end
         TSV_VECTOR_OFS: begin
            rd_d = {16'h0000, vec_rd};
         end
         TSV_IRQ_MASK_OFS: begin
            rd_d = {16'h0000, mask_rd};
         end
         default: begin
            rd_d = 32'h00000000;
         end
      endcase
   end

   // ------------------------------------------------------------
   // bus answer next values
   // ------------------------------------------------------------
   always_comb begin
      ack_d = 1'b0;
      err_d = 1'b0;
      dat_d = 32'h00000000;
      if (req) begin
         if (hit) begin
            ack_d = 1'b1;
            if (rd_req) begin
               dat_d = rd_d;
            end
         end else begin
            err_d = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // bus answer, one cycle after request
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= ack_d;
         err_q <= err_d;
         dat_q <= dat_d;
      end
   end

   // ------------------------------------------------------------
   // outputs, straight from flip-flops
   // ------------------------------------------------------------
   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
   assign wb_dat_o = dat_q;
   assign irq_o = irq_q;
endmodule

// ===== src/tsv_vector_filter.sv
// vector report holder that screens out reserved codes
`timescale 1ns/1ps
module tsv_vector_filter
   import tsv_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire tsv_pending_type pend_i,
   output logic [3:0] level_o,
   output logic [7:0] vector_o
);
   logic [3:0] level_q;
   logic [7:0] vector_q;
   logic rsvd;

   // ------------------------------------------------------------
   // reserved code screen
   // ------------------------------------------------------------
   assign rsvd = (pend_i.vector == TSV_VEC_RSVD_LO) || (pend_i.vector == TSV_VEC_RSVD_HI); // [RL9]

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_q <= TSV_LEVEL_RST; // [RL10]
         vector_q <= TSV_VECTOR_RST;
      end else if (!pend_i.valid) begin
         level_q <= TSV_LEVEL_RST;
         vector_q <= TSV_VECTOR_RST;
      end else if (!rsvd) begin
         level_q <= pend_i.level; // [RL5]
         vector_q <= pend_i.vector; // [RL6] [RL7] [RL8]
      end
   end

   assign level_o = level_q;
   assign vector_o = vector_q;
endmodule

// ===== verif/tsv_checker.sv
// assertion checker for the trap status block
`timescale 1ns/1ps
module tsv_checker
   import tsv_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire tsv_event_type event_i,
   input wire tsv_pending_type pend_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_rd(logic [3:0] ofs);
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == ofs;
   endsequence
   property p_soft_zero;
      s_rd(TSV_SOFT_TRAP_OFS) |-> wb_dat_o[31:6] == 0 && wb_dat_o[3:0] == 0; endproperty
   a_soft_zero: assert property (p_soft_zero) else $error("soft spare bits set");
   property p_hard_zero;
      s_rd(TSV_HARD_TRAP_OFS) |-> wb_dat_o[31:1] == 0; endproperty
   a_hard_zero: assert property (p_hard_zero) else $error("hard spare bits set");
   property p_vec_zero;
      s_rd(TSV_VECTOR_OFS) |-> wb_dat_o[31:12] == 0; endproperty
   a_vec_zero: assert property (p_vec_zero) else $error("report spare bits set");
   property p_dma;
      event_i.dma_addr_err ##2 s_rd(TSV_SOFT_TRAP_OFS) |-> wb_dat_o[5]; endproperty
   a_dma: assert property (p_dma) else $error("dma flag not set");
   property p_loop;
      event_i.loop_stack_ovf ##2 s_rd(TSV_SOFT_TRAP_OFS) |-> wb_dat_o[4]; endproperty
   a_loop: assert property (p_loop) else $error("loop flag not set");
   property p_hard;
      event_i.sw_hard_trap ##2 s_rd(TSV_HARD_TRAP_OFS) |-> wb_dat_o[0]; endproperty
   a_hard: assert property (p_hard) else $error("hard flag not set");
   property p_vec;
      s_rd(TSV_VECTOR_OFS) ##0 ($past(pend_i.valid, 2) && $past(pend_i.vector, 2) != 8'h07
         && $past(pend_i.vector, 2) != 8'hff)
         |-> wb_dat_o[11:0] == {$past(pend_i.level, 2), $past(pend_i.vector, 2)}; endproperty
   a_vec: assert property (p_vec) else $error("report mismatch");
   property p_rsvd;
      s_rd(TSV_VECTOR_OFS) |-> wb_dat_o[7:0] != 8'h07 && wb_dat_o[7:0] != 8'hff; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved vector shown");
endmodule
bind tsv_trap_status tsv_checker u_chk (.*);

// ===== verif/tsv_trap_status_bench.sv
// self-checking bench for the trap status block
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module tsv_trap_status_bench;
   import tsv_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, err, irq, rerr;
   logic [3:0] adr = '0, sel = 4'hf;
   logic [31:0] wdat = '0, rdo, rdat;
   tsv_event_type ev = '0;
   tsv_pending_type pend = '0;
   int error_cnt = 0, num_checks = 0;
   logic [7:0] codes [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09};
   tsv_trap_status DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdo),
      .wb_ack_o(ack), .wb_err_o(err), .event_i(ev), .pend_i(pend), .irq_o(irq));
   initial forever #4 clk_i = ~clk_i;
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
      rdat = rdo;
      rerr = err;
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK("read", e, rdat)
   endtask
   task automatic pulse(input tsv_event_type e);
      ev <= e;
      @(posedge clk_i);
      ev <= '0;
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #10us;
      error_cnt++;
      end_of_test();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rchk(TSV_SOFT_TRAP_OFS, 32'h0);
      rchk(TSV_HARD_TRAP_OFS, 32'h0);
      rchk(TSV_VECTOR_OFS, 32'h0);
      `CHK("irq", 1'b0, irq)
      pulse(3'b100);
      rchk(TSV_SOFT_TRAP_OFS, 32'h20);
      pulse(3'b010);
      rchk(TSV_SOFT_TRAP_OFS, 32'h30);
      pulse(3'b001);
      rchk(TSV_HARD_TRAP_OFS, 32'h1);
      `CHK("irq", 1'b0, irq)
      bus(1'b1, TSV_IRQ_MASK_OFS, 32'h7);
      rchk(TSV_IRQ_MASK_OFS, 32'h7);
      `CHK("irq", 1'b1, irq)
      bus(1'b1, TSV_IRQ_MASK_OFS, 32'h0);
      `CHK("irq", 1'b0, irq)
      ev <= 3'b100;
      bus(1'b1, TSV_SOFT_TRAP_OFS, 32'h20);
      ev <= '0;
      rchk(TSV_SOFT_TRAP_OFS, 32'h30);
      sel <= 4'he;
      bus(1'b1, TSV_SOFT_TRAP_OFS, 32'h30);
      sel <= 4'hf;
      rchk(TSV_SOFT_TRAP_OFS, 32'h30);
      bus(1'b1, TSV_SOFT_TRAP_OFS, 32'hffff_ffff);
      bus(1'b1, TSV_HARD_TRAP_OFS, 32'hffff_ffff);
      rchk(TSV_SOFT_TRAP_OFS, 32'h0);
      rchk(TSV_HARD_TRAP_OFS, 32'h0);
      `CHK("irq", 1'b0, irq)
      foreach (codes[i]) begin
         pend <= {1'b1, 4'(codes[i] * 3), codes[i]};
         repeat (2) @(posedge clk_i);
         rchk(TSV_VECTOR_OFS, {20'h0, 4'(codes[i] * 3), codes[i]});
      end
      pend.vector <= TSV_VEC_RSVD_LO;
      repeat (2) @(posedge clk_i);
      rchk(TSV_VECTOR_OFS, 32'hb09);
      pend.vector <= TSV_VEC_RSVD_HI;
      repeat (2) @(posedge clk_i);
      rchk(TSV_VECTOR_OFS, 32'hb09);
      bus(1'b1, TSV_VECTOR_OFS, 32'hffff);
      rchk(TSV_VECTOR_OFS, 32'hb09);
      bus(1'b0, 4'h2, 32'h0);
      `CHK("err", 1'b1, rerr)
      end_of_test();
   end
endmodule
